//--- core/dsp_shift_unit.sv
`timescale 1ns/1ps
`include "dsp_shift_params.svh"
// Behaviour
// - Immediate arithmetic shift uses only low seven immediate bits as signed amount
// - Immediate arithmetic shift reads its source from the destination register
// - Source guard is all ones when source top bit set, else zero
// - Amount bit 6 clear: left shift 0..32, shifted-out bits enter guard
// - Amount bit 6 set: right shift by inverted low bits plus one
// - Right shift replicates guard sign; guard byte shifts arithmetically too
// - Arithmetic left shift carry is bit 0 of result guard
// - Arithmetic right shift carry is last source bit shifted out
// - Overflow when result fits neither range; then apply configured saturation
// - Accumulator destinations store result and guard, guard sign-extended on read
// - Other legal selectors write X0..M1; any other selector is illegal
// - Arithmetic negative is guard bit 7; zero needs result and guard zero
// - Logical shift works on upper word, clears destination lower word
// - Logical shift into accumulator also clears its guard
// - Positive amount shifts left, negative right, from register or immediate
// - Unconditional register logical shift decoded from 10000001 after prefix, one cycle
// - Immediate logical shift is unconditional and shifts destination in place
// - Unconditional shift updates condition flag per flag-select field
// - Unconditional shift updates negative, zero, overflow, greater flags
// - Conditional shift leaves all status flags unchanged
// - Logical left count is low five bits, at most sixteen
// - Logical shift clears carry and overflow; N top bit, Z upper word
module dsp_shift_unit #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire dsp_shift_pkg::word_t pwdata,
  output dsp_shift_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  output logic illegal_insn
);
  import dsp_shift_pkg::*;

  // ****************************************************************
  // Destination and source selector decoding
  // ****************************************************************

  // Codes 5 and 7 are the accumulators; every gap in the code list is illegal
  // Maps a four-bit selector to {legal, register index}
  function automatic logic [3:0] dest_index(input logic [3:0] sel);
    logic [3:0] r;
    r = 4'h0;
    unique case (sel)
      4'h5: r = 4'hF;
      4'h7: r = 4'hE;
      4'h8: r = 4'h8;
      4'h9: r = 4'h9;
      4'hA: r = 4'hA;
      4'hB: r = 4'hB;
      4'hC: r = 4'hC;
      4'hE: r = 4'hD;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Sign fill of a 32-bit word into a guard byte
  function automatic logic [7:0] guard_of(input logic [31:0] w);
    return w[31] ? 8'hFF : 8'h00;
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  // Index 0 X0, 1 X1, 2 Y0, 3 Y1, 4 M0, 5 M1, 6 A0, 7 A1
  word_t dreg_q [0:7];
  // Guard bytes of the two accumulators
  logic [7:0] acc0_guard_q;
  logic [7:0] acc1_guard_q;
  // Status register, then sticky illegal and last-skip flags
  word_t dsr_q;
  logic illegal_q;
  logic skipped_q;
  // Bus answer
  logic pready_q;
  logic pslverr_q;
  word_t prdata_q;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Access phase; ready rises in its second cycle
  wire acc_phase = psel & penable;
  wire first_acc = acc_phase & ~pready_q;
  wire xfer_done = acc_phase & pready_q;
  // Writes land only at the completing edge of a mapped access
  wire wr_en = xfer_done & pwrite & ~pslverr_q;
  wire [7:0] addr8 = 8'(paddr);
  // Aligned words up to the status register are mapped
  wire addr_ok = (addr8[1:0] == 2'b00) && (addr8 <= `OFF_STATUS);
  // Register hits
  wire hit_dreg = addr_ok && (addr8 < `OFF_ACC0_GUARD);
  wire hit_g0 = addr_ok && (addr8 == `OFF_ACC0_GUARD);
  wire hit_g1 = addr_ok && (addr8 == `OFF_ACC1_GUARD);
  wire hit_dsr = addr_ok && (addr8 == `OFF_DSR);
  wire hit_insn = addr_ok && (addr8 == `OFF_INSN);
  wire hit_status = addr_ok && (addr8 == `OFF_STATUS);
  // Word index of the data registers
  wire [2:0] rd_idx = addr8[4:2];
  // Issuing an instruction is a write to its register
  wire insn_wr = wr_en & hit_insn;

  // Status word: bit 1 skipped, bit 0 illegal
  wire [31:0] status_word = {30'h00000000, skipped_q, illegal_q};
  // Read selection; guards read back sign-extended
  wire [31:0] rd_val = hit_dreg ? dreg_q[rd_idx] :
                       hit_g0 ? {{24{acc0_guard_q[7]}}, acc0_guard_q} :
                       hit_g1 ? {{24{acc1_guard_q[7]}}, acc1_guard_q} :
                       hit_dsr ? dsr_q :
                       hit_status ? status_word : 32'h00000000;

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  // Prefix in the upper half, second instruction word in the lower half
  wire [15:0] pre_w = pwdata[31:16];
  wire [15:0] op_w = pwdata[15:0];
  wire is_prefix = pre_w[15:10] == `PREFIX_CODE;
  // Top bits of the second word pick the shift form
  wire lsh_reg_pat = is_prefix && (op_w[15:10] == `LSH_REG_TOP) && (op_w[9:8] != 2'b00);
  wire lsh_imm_pat = is_prefix && (op_w[15:11] == `LSH_IMM_TOP);
  wire ash_imm_pat = is_prefix && (op_w[15:11] == `ASH_IMM_TOP);
  // Operand selector fields of the second word
  wire [1:0] src_sel = op_w[7:6];
  wire [1:0] amt_sel = op_w[5:4];
  wire [3:0] dest_sel = op_w[3:0];
  // Immediate amount; higher field bits never reach the shifters
  wire [6:0] imm7 = op_w[10:4] & `ASH_AMT_MASK;

  // Shift form; any other pattern is refused
  op_t op;
  assign op = lsh_reg_pat ? OP_LSH_REG :
              lsh_imm_pat ? OP_LSH_IMM :
              ash_imm_pat ? OP_ASH_IMM : OP_NONE;

  // Condition: register logical forms carry it in bits 9:8
  cond_t cond;
  assign cond = (op == OP_LSH_REG) ? cond_t'(op_w[9:8]) :
                (op == OP_NONE) ? EXEC_NEVER : EXEC_ALWAYS;

  // Destination decode; the top bit says the selector is legal
  wire [3:0] dest_dec = dest_index(dest_sel);
  wire dest_legal = dest_dec[3];
  wire [2:0] dest_idx = dest_dec[2:0];
  // Indexes 6 and 7 are the accumulators, which own guard bytes
  wire dest_is_acc = dest_idx[2] & dest_idx[1];
  // Source codes 2 and 3 land on the accumulators; amount codes start at Y0
  wire [2:0] src_idx = {src_sel[1], src_sel[1], src_sel[0]};
  wire [2:0] amt_idx = 3'(amt_sel) + 3'h2;

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  // Arithmetic immediate form shifts the destination in place
  wire [31:0] ash_src = dreg_q[dest_idx];
  // Guard is rebuilt from the source sign, never read from storage
  wire [7:0] ash_guard = guard_of(ash_src);
  // Logical register form reads its own source; the amount sits in bits 21:16
  wire [31:0] lsh_src = (op == OP_LSH_IMM) ? dreg_q[dest_idx] : dreg_q[src_idx];
  wire [5:0] lsh_amt = (op == OP_LSH_IMM) ? imm7[5:0] : dreg_q[amt_idx][21:16];

  // Result bundles of the two shifters
  shift_res_if ash_res ();
  shift_res_if lsh_res ();

  // Arithmetic shifter always sees the immediate amount
  arith_shifter u_ash (
    .shift_source(ash_src),
    .src_guard(ash_guard),
    .amount(imm7),
    .res(ash_res)
  );

  // Logical shifter works on the upper word only
  logic_shifter u_lsh (
    .src_hi(lsh_src[31:16]),
    .amount(lsh_amt),
    .imm_form(op == OP_LSH_IMM),
    .res(lsh_res)
  );

  // ****************************************************************
  // Overflow check and protection on the arithmetic path
  // ****************************************************************
  wire [39:0] ash_raw = {ash_res.guard, ash_res.dst};
  // Result fits when the guard only repeats bit 31
  wire pos_fits = (ash_res.guard == 8'h00) && ~ash_res.dst[31];
  wire neg_fits = (ash_res.guard == 8'hFF) && ash_res.dst[31];
  wire ash_ovf = ~(pos_fits | neg_fits);
  // Protection clamps to the largest value of the result's sign
  wire sat_en = dsr_q[`DSR_SAT];
  wire [39:0] ash_sat = ash_raw[39] ? `SAT_NEG : `SAT_POS;
  wire [39:0] ash_fin = (ash_ovf & sat_en) ? ash_sat : ash_raw;

  // ****************************************************************
  // Common result and flags
  // ****************************************************************
  // Arithmetic or logical result, picked by the issued form
  wire is_ash = op == OP_ASH_IMM;
  wire [31:0] res_dst = is_ash ? ash_fin[31:0] : lsh_res.dst;
  wire [7:0] res_guard = is_ash ? ash_fin[39:32] : lsh_res.guard;
  wire bad_cnt = is_ash ? ash_res.bad_cnt : lsh_res.bad_cnt;

  // Status flags of the finished result
  wire flag_n = is_ash ? res_guard[7] : res_dst[31];
  wire flag_z = is_ash ? (res_dst == 32'h00000000) && (res_guard == 8'h00) :
                (res_dst[31:16] == 16'h0000);
  wire flag_v = is_ash & ash_ovf;
  wire flag_c = is_ash ? ash_res.carry : lsh_res.carry;
  wire flag_gt = ~flag_n & ~flag_z;

  // Condition flag chosen by the flag-select field
  wire [2:0] cs = dsr_q[`DSR_CS_HI:`DSR_CS_LO];
  wire cond_new = (cs == `CS_CARRY) ? flag_c :
                  (cs == `CS_NEG) ? flag_n :
                  (cs == `CS_ZERO) ? flag_z :
                  (cs == `CS_OVF) ? flag_v :
                  (cs == `CS_GREATER) ? flag_gt :
                  (cs == `CS_GE) ? ~flag_n : 1'b0;

  // ****************************************************************
  // Execution control
  // ****************************************************************
  // Condition flag as it stood before this instruction
  wire cond_flag = dsr_q[`DSR_COND];
  // A bad count or selector refuses the whole instruction
  wire legal = (op != OP_NONE) & dest_legal & ~bad_cnt;
  wire cond_ok = (cond == EXEC_ALWAYS) |
                 ((cond == EXEC_IF_SET) & cond_flag) |
                 ((cond == EXEC_IF_CLEAR) & ~cond_flag);
  wire run = insn_wr & legal & cond_ok;
  // Only unconditional forms touch the status flags
  wire upd_flags = run & (cond == EXEC_ALWAYS);
  wire set_illegal = insn_wr & ~legal;

  // Flag image written back by an unconditional shift
  word_t dsr_flags;
  always_comb begin
    dsr_flags = dsr_q;
    dsr_flags[`DSR_COND] = cond_new;
    dsr_flags[`DSR_N] = flag_n;
    dsr_flags[`DSR_Z] = flag_z;
    dsr_flags[`DSR_V] = flag_v;
    dsr_flags[`DSR_GREATER] = flag_gt;
  end

  // Flag update beats a software write; the two never meet
  wire sw_dsr_wr = wr_en & hit_dsr;
  wire [31:0] dsr_d = upd_flags ? dsr_flags :
                      sw_dsr_wr ? (pwdata & `DSR_WMASK) : dsr_q;

  // Sticky illegal flag, cleared by writing one; a new event wins
  wire clr_illegal = wr_en & hit_status & pwdata[`ST_ILLEGAL];
  wire illegal_d = set_illegal | (illegal_q & ~clr_illegal);
  wire skipped_d = insn_wr ? (legal & ~cond_ok) : skipped_q;

  // ****************************************************************
  // Data register file
  // ****************************************************************
  // One process per register; each element has a single writer
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dreg
      // Execution result wins over a software write in the same cycle
      wire sw_hit = wr_en & hit_dreg & (rd_idx == 3'(gi));
      wire ex_hit = run & (dest_idx == 3'(gi));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dreg_q[gi] <= 32'h00000000;
        end else if (ex_hit) begin
          dreg_q[gi] <= res_dst;
        end else if (sw_hit) begin
          dreg_q[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // Accumulator guards: arithmetic stores the result guard, logical clears it
  wire g0_ex = run & dest_is_acc & ~dest_idx[0];
  wire g1_ex = run & dest_is_acc & dest_idx[0];
  wire [7:0] acc0_guard_d = g0_ex ? res_guard : (wr_en & hit_g0) ? pwdata[7:0] : acc0_guard_q;
  wire [7:0] acc1_guard_d = g1_ex ? res_guard : (wr_en & hit_g1) ? pwdata[7:0] : acc1_guard_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc0_guard_q <= 8'h00;
      acc1_guard_q <= 8'h00;
    end else begin
      acc0_guard_q <= acc0_guard_d;
      acc1_guard_q <= acc1_guard_d;
    end
  end

  // Status register, sticky and skip flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_q <= `DSR_RESET;
      illegal_q <= 1'b0;
      skipped_q <= 1'b0;
    end else begin
      dsr_q <= dsr_d;
      illegal_q <= illegal_d;
      skipped_q <= skipped_d;
    end
  end

  // ****************************************************************
  // APB answer: one wait state, registered data and error
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= first_acc;
      pslverr_q <= first_acc & ~addr_ok;
      prdata_q <= (first_acc & ~pwrite & addr_ok) ? rd_val : 32'h00000000;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready = pready_q;
  // Error only shows while ready stands
  assign pslverr = pready_q & pslverr_q;
  assign prdata = prdata_q;
  assign illegal_insn = illegal_q;
  // Note: a shifter whose bad-count flag is raised never writes a register.
  // Software sees such a request only through the sticky illegal flag.
endmodule

//--- core/dsp_shift_params.svh
`ifndef DSP_SHIFT_PARAMS_SVH
`define DSP_SHIFT_PARAMS_SVH

// ****************************************************************
// Register byte offsets on the APB side
// ****************************************************************
`define OFF_X0 8'h00
`define OFF_X1 8'h04
`define OFF_Y0 8'h08
`define OFF_Y1 8'h0C
`define OFF_M0 8'h10
`define OFF_M1 8'h14
`define OFF_A0 8'h18
`define OFF_A1 8'h1C
`define OFF_ACC0_GUARD 8'h20
`define OFF_ACC1_GUARD 8'h24
`define OFF_DSR 8'h28
`define OFF_INSN 8'h2C
`define OFF_STATUS 8'h30

// ****************************************************************
// Status register fields
// ****************************************************************
`define DSR_COND 0
`define DSR_N 1
`define DSR_Z 2
`define DSR_V 3
`define DSR_GREATER 4
`define DSR_CS_LO 5
`define DSR_CS_HI 7
`define DSR_SAT 8
`define DSR_WMASK 32'h000001FF
`define DSR_RESET 32'h00000000
`define ST_ILLEGAL 0
`define ST_SKIPPED 1

// ****************************************************************
// Flag-select codes for the condition flag
// ****************************************************************
`define CS_CARRY 3'h0
`define CS_NEG 3'h1
`define CS_ZERO 3'h2
`define CS_OVF 3'h3
`define CS_GREATER 3'h4
`define CS_GE 3'h5

// ****************************************************************
// Instruction decode constants and limits
// ****************************************************************
`define PREFIX_CODE 6'h3E
`define LSH_REG_TOP 6'h20
`define LSH_IMM_TOP 5'h00
`define ASH_IMM_TOP 5'h02
`define ASH_AMT_MASK 7'h7F
`define ASH_MAX_CNT 7'h20
`define LSH_MAX_CNT 6'h10
`define SAT_POS 40'h007FFFFFFF
`define SAT_NEG 40'hFF80000000

`endif

//--- core/dsp_shift_pkg.sv
package dsp_shift_pkg;

  typedef logic [31:0] word_t;

  // Which shift the issued instruction asks for
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ASH_IMM = 2'b01,
    OP_LSH_REG = 2'b10,
    OP_LSH_IMM = 2'b11
  } op_t;

  // Execution condition of a shift
  typedef enum logic [1:0] {
    EXEC_NEVER = 2'b00,
    EXEC_ALWAYS = 2'b01,
    EXEC_IF_SET = 2'b10,
    EXEC_IF_CLEAR = 2'b11
  } cond_t;

endpackage

//--- core/shift_res_if.sv
`timescale 1ns/1ps
// Result bundle from a shifter to the unit
interface shift_res_if;
  logic [31:0] dst;
  logic [7:0] guard;
  logic carry;
  logic bad_cnt;
  modport prod (output dst, output guard, output carry, output bad_cnt);
  modport cons (input dst, input guard, input carry, input bad_cnt);
endinterface

//--- core/arith_shifter.sv
`timescale 1ns/1ps
`include "dsp_shift_params.svh"
// 40-bit arithmetic shifter, left or right by the sign of the amount
module arith_shifter (
  input wire logic [31:0] shift_source,
  input wire logic [7:0] src_guard,
  input wire logic [6:0] amount,
  shift_res_if.prod res
);
  wire [39:0] src40 = {src_guard, shift_source};
  wire go_right = amount[6];
  wire [5:0] lcnt = amount[5:0];
  wire [6:0] rcnt = {1'b0, ~amount[5:0]} + 7'h01;
  wire [39:0] left40 = src40 << lcnt;
  wire [39:0] right40 = 40'($signed(src40) >>> rcnt);
  wire [31:0] out_bits = shift_source >> 7'(rcnt - 7'h01);

  // Left moves top bits into the guard, right replicates the guard sign
  assign res.dst = go_right ? right40[31:0] : left40[31:0];
  assign res.guard = go_right ? right40[39:32] : left40[39:32];
  assign res.carry = go_right ? out_bits[0] : left40[32];
  assign res.bad_cnt = go_right ? (rcnt > `ASH_MAX_CNT) : ({1'b0, lcnt} > `ASH_MAX_CNT);
endmodule

//--- core/logic_shifter.sv
`timescale 1ns/1ps
`include "dsp_shift_params.svh"
// 16-bit logical shifter on the upper word, zero fill at both ends
module logic_shifter (
  input wire logic [15:0] src_hi,
  input wire logic [5:0] amount,
  input wire logic imm_form,
  shift_res_if.prod res
);
  wire go_right = amount[5];
  wire [4:0] lcnt = amount[4:0];
  wire [5:0] rmask = imm_form ? {1'b0, ~amount[4:0]} : {2'b00, ~amount[3:0]};
  wire [5:0] rcnt = rmask + 6'h01;
  wire [15:0] left_hw = src_hi << lcnt;
  wire [15:0] right_hw = src_hi >> rcnt;

  // Result sits in the upper word; low word and guard are zero
  assign res.dst = {go_right ? right_hw : left_hw, 16'h0000};
  assign res.guard = 8'h00;
  assign res.carry = 1'b0;
  assign res.bad_cnt = go_right ? (rcnt > `LSH_MAX_CNT) : ({1'b0, lcnt} > `LSH_MAX_CNT);
endmodule

//--- bench/dsp_shift_unit_properties.sv
`timescale 1ns/1ps
`include "dsp_shift_params.svh"
// Port checker for the shift unit: bus timing, refusals and the illegal flag
module dsp_shift_unit_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire dsp_shift_pkg::word_t pwdata,
  input wire dsp_shift_pkg::word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic illegal_insn
);
  import dsp_shift_pkg::*;
  // ****************************************************************
  // Helper decode
  // ****************************************************************
  logic insn_wr_q;
  logic mapped;
  logic clr_wr;
  // Aligned address inside the register map, and a clearing status write
  assign mapped = (paddr[7:0] <= `OFF_STATUS) && (paddr[1:0] == 2'h0);
  assign clr_wr = pready && pwrite && (paddr[7:0] == `OFF_STATUS) && pwdata[0];
  // Remembers that an instruction write completed on the last edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_wr_q <= 1'b0;
    end else begin
      insn_wr_q <= pready && pwrite && (paddr[7:0] == `OFF_INSN);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Answer comes in the second access cycle, so an instruction completes in one transfer
  a_ready_one_wait: assert property ((psel && penable && !$past(penable)) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && (prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  a_insn_reads_zero: assert property (pready && !pwrite && (paddr[7:0] == `OFF_INSN) |-> prdata == 32'h0)
    else $error("instruction register readable");
  a_illegal_from_insn: assert property ($rose(illegal_insn) |-> insn_wr_q)
    else $error("illegal flag set without instruction");
  a_illegal_sticky: assert property (illegal_insn && !clr_wr |=> illegal_insn)
    else $error("illegal flag dropped without clear");
  a_illegal_clears: assert property (clr_wr |=> !illegal_insn)
    else $error("illegal flag not cleared");
  a_status_mirror: assert property (pready && !pwrite && (paddr[7:0] == `OFF_STATUS) |-> prdata[0] == illegal_insn)
    else $error("status bit differs from illegal flag");
endmodule

bind dsp_shift_unit dsp_shift_unit_properties #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .illegal_insn(illegal_insn)
);

//--- bench/apb_host.sv
`timescale 1ns/1ps
// Bus master standing in for the core that issues words to the shift unit
module apb_host #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output dsp_shift_pkg::word_t pwdata,
  input wire dsp_shift_pkg::word_t prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import dsp_shift_pkg::*;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end
  // One transfer, request held until ready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr, input word_t data,
                      output word_t rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~data; // Released data no longer shows the last value
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
`include "dsp_shift_params.svh"
// Self-checking bench for the shift unit
module tb;
  import dsp_shift_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  word_t pwdata;
  word_t prdata;
  logic pready;
  logic pslverr;
  logic illegal_insn;
  word_t rd_v;
  logic err_v;
  int fails;
  int checked;
  logic [3:0] dest_code [8] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'h7, 4'h5};
  logic [7:0] doff [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [6:0] rs_imm [4] = '{7'h7B, 7'h74, 7'h60, 7'h7F};
  word_t rs_src [4] = '{32'h80000010, 32'h80000010, 32'h80000000, 32'h00000100};
  word_t rs_res [4] = '{32'hFC000000, 32'hFFF80000, 32'hFFFFFFFF, 32'h00000080};
  word_t rs_dsr [4] = '{32'h3, 32'h2, 32'h3, 32'h10};

  dsp_shift_unit #(.ADDR_W(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .illegal_insn(illegal_insn));
  apb_host #(.ADDR_W(8)) u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Clock at 4 ns
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string what, input word_t seen, input word_t exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input word_t d, input logic e);
    u_host.xfer(1'b1, a, d, rd_v, err_v);
    chk("write error", {31'h0, err_v}, {31'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input word_t e, input logic ee);
    u_host.xfer(1'b0, a, 32'h0, rd_v, err_v);
    chk($sformatf("read %h", a), rd_v, e);
    chk("read error", {31'h0, err_v}, {31'h0, ee});
  endtask
  task automatic issue(input logic [15:0] w2);
    wr(`OFF_INSN, {16'hF800, w2}, 1'b0);
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    fails = 0;
    checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h30; a += 4) rd(8'(a), 32'h0, 1'b0);
    rd(8'h34, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    wr(8'h40, 32'hFFFFFFFF, 1'b1);
    // Every destination code shifts its own value left by one
    for (int i = 0; i < 8; i++) begin
      wr(doff[i], 32'h00001234, 1'b0);
      issue({5'b00010, 7'h01, dest_code[i]});
      rd(doff[i], 32'h00002468, 1'b0);
      rd(`OFF_DSR, 32'h10, 1'b0);
    end
    rd(`OFF_ACC0_GUARD, 32'h0, 1'b0);
    rd(`OFF_ACC1_GUARD, 32'h0, 1'b0);
    // Each flag-select code on a negative left result with carry out
    for (int cs = 0; cs < 8; cs++) begin
      wr(`OFF_DSR, 32'(cs) << 5, 1'b0);
      wr(`OFF_A0, 32'hF8765432, 1'b0);
      issue({5'b00010, 7'h04, 4'h7});
      rd(`OFF_DSR, (32'(cs) << 5) | 32'h2 | {31'h0, cs < 2}, 1'b0);
    end
    rd(`OFF_A0, 32'h87654320, 1'b0);
    rd(`OFF_ACC0_GUARD, 32'hFFFFFFFF, 1'b0);
    // Right shifts: short, past the guard, full width, positive source
    wr(`OFF_DSR, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_X1, rs_src[i], 1'b0);
      issue({5'b00010, rs_imm[i], 4'h9});
      rd(`OFF_X1, rs_res[i], 1'b0);
      rd(`OFF_DSR, rs_dsr[i], 1'b0);
    end
    // Overflow without and with saturation
    wr(`OFF_X0, 32'h40000000, 1'b0);
    issue({5'b00010, 7'h01, 4'h8});
    rd(`OFF_X0, 32'h80000000, 1'b0);
    rd(`OFF_DSR, 32'h18, 1'b0);
    wr(`OFF_DSR, 32'h100, 1'b0);
    wr(`OFF_X0, 32'h40000000, 1'b0);
    issue({5'b00010, 7'h01, 4'h8});
    rd(`OFF_X0, 32'h7FFFFFFF, 1'b0);
    rd(`OFF_DSR, 32'h118, 1'b0);
    // Refused instructions leave the destination alone
    wr(`OFF_X0, 32'h5, 1'b0);
    issue({5'b00010, 7'h21, 4'h8});
    issue({5'b00010, 7'h01, 4'h6});
    issue({5'b00000, 7'h11, 4'h8});
    rd(`OFF_X0, 32'h5, 1'b0);
    chk("illegal", {31'h0, illegal_insn}, 32'h1);
    wr(`OFF_STATUS, 32'h1, 1'b0);
    rd(`OFF_STATUS, 32'h0, 1'b0);
    // Logical shifts, register and immediate amounts
    wr(`OFF_DSR, 32'h0, 1'b0);
    wr(`OFF_X0, 32'h22222222, 1'b0);
    wr(`OFF_Y0, 32'h00030000, 1'b0);
    wr(`OFF_ACC0_GUARD, 32'h7F, 1'b0);
    wr(`OFF_A0, 32'h9A9A9A9A, 1'b0);
    issue({8'h81, 2'h0, 2'h0, 4'h7});
    rd(`OFF_A0, 32'h11100000, 1'b0);
    rd(`OFF_ACC0_GUARD, 32'h0, 1'b0);
    rd(`OFF_DSR, 32'h10, 1'b0);
    wr(`OFF_X1, 32'hCCCCCCCC, 1'b0);
    wr(`OFF_Y1, 32'hFFFE0000, 1'b0);
    issue({8'h81, 2'h1, 2'h1, 4'h9});
    rd(`OFF_X1, 32'h33330000, 1'b0);
    wr(`OFF_X0, 32'h0001FFFF, 1'b0);
    issue({5'b00000, 7'h10, 4'h8});
    rd(`OFF_X0, 32'h0, 1'b0);
    rd(`OFF_DSR, 32'h4, 1'b0);
    wr(`OFF_X1, 32'h80000000, 1'b0);
    issue({5'b00000, 7'h31, 4'h9});
    rd(`OFF_X1, 32'h00010000, 1'b0);
    // Conditional forms with the condition flag set, then clear
    wr(`OFF_DSR, 32'h1, 1'b0);
    wr(`OFF_X0, 32'h00010000, 1'b0);
    wr(`OFF_Y0, 32'h00010000, 1'b0);
    issue({8'h82, 2'h0, 2'h0, 4'h8});
    rd(`OFF_X0, 32'h00020000, 1'b0);
    rd(`OFF_DSR, 32'h1, 1'b0);
    issue({8'h83, 2'h0, 2'h0, 4'h8});
    rd(`OFF_X0, 32'h00020000, 1'b0);
    rd(`OFF_STATUS, 32'h2, 1'b0);
    wr(`OFF_DSR, 32'h0, 1'b0);
    issue({8'h83, 2'h0, 2'h0, 4'h8});
    rd(`OFF_X0, 32'h00040000, 1'b0);
    rd(`OFF_DSR, 32'h0, 1'b0);
    issue({8'h82, 2'h0, 2'h0, 4'h8});
    rd(`OFF_X0, 32'h00040000, 1'b0);
    close_out();
  end
endmodule
